// ---- hdl/cpu_bitop_transfer_exec.sv ----
`include "cpu_exec_consts.svh"
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1: Rotate left through carry, update Z C N V, one cycle.
// RULE2: Rotate right through carry, update Z C N V, one cycle.
// RULE3: Bit store copies chosen source bit into T only, one cycle.
// RULE4: Bit load copies T into chosen destination bit, flags kept, one cycle.
// RULE5: Flag set or clear forces only the named status bit, one cycle.
// RULE6: Post-increment load reads at pointer then bumps pointer, two cycles.
// RULE7: Pre-decrement load drops pointer first then reads there, two cycles.
// RULE8: Displacement load reads at Y or Z plus offset, pointer kept.
// RULE9: Direct load reads immediate data address into register, two cycles.
// RULE10: Post-increment store writes at pointer then bumps it, two cycles.
// RULE11: Pre-decrement store drops pointer then writes there, two cycles.
// RULE12: Displacement store writes at Y or Z plus offset, pointer kept.
// RULE13: Direct store writes source to immediate data address, two cycles.
// RULE14: Code read via Z into register or R0, optional increment, three cycles.
// RULE15: Push puts register on stack in two cycles, flags kept.
// RULE16: Pop loads register from stack in two cycles, flags kept.
// RULE17: Sleep issues in one cycle, no flags, pulses sleep request.
// RULE18: Watchdog restart issues in one cycle, no flags, pulses restart.
// RULE19: Pointers are 16-bit register pairs, low byte lower, full carry.
module cpu_bitop_transfer_exec (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic ISSUE_VALID,
  output logic ISSUE_READY,
  input wire logic [4:0] OP_SEL,
  input wire logic [4:0] DST_REG,
  input wire logic [4:0] SRC_REG,
  input wire logic [2:0] BIT_SEL,
  input wire logic [2:0] FLAG_SEL,
  input wire logic [1:0] PTR_SEL,
  input wire logic [1:0] PTR_MODE,
  input wire logic [5:0] DISP_Q,
  input wire logic [15:0] DIRECT_ADDR,
  input wire logic NO_OPERAND,
  output logic DONE,
  output logic [15:0] DMEM_ADDR,
  output logic DMEM_RD_EN,
  output logic DMEM_WR_EN,
  output logic [7:0] DMEM_WDATA,
  input wire logic [7:0] DMEM_RDATA,
  output logic [15:0] PMEM_ADDR,
  output logic PMEM_RD_EN,
  input wire logic [7:0] PMEM_RDATA,
  output logic SLEEP_REQ,
  output logic WDOG_RESTART,
  output logic [7:0] FLAGS_OUT,
  output logic [15:0] STACK_PTR,
  input wire logic [4:0] DBG_REG_SEL,
  output logic [7:0] DBG_REG_DATA
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  cpu_exec_pkg::state_t st_q;
  cpu_exec_pkg::state_t st_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [7:0] rf_q [32];
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic [15:0] daddr_q;
  logic drd_q;
  logic dwr_q;
  logic [7:0] wdata_q;
  logic [15:0] paddr_q;
  logic prd_q;
  logic [4:0] ld_idx_q;
  logic sleep_q;
  logic wdr_q;
  logic done_q;
  logic [7:0] dbg_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  cpu_exec_pkg::op_t op;
  logic issue;
  logic is_rol;
  logic is_ror;
  logic is_bst;
  logic is_bld;
  logic is_fset;
  logic is_fclr;
  logic is_ild;
  logic is_old;
  logic is_dld;
  logic is_ist;
  logic is_ost;
  logic is_dst;
  logic is_lpm;
  logic is_push;
  logic is_pop;
  logic is_sleep;
  logic is_wdr;
  logic is_dload;
  logic is_dstore;
  logic is_multi;

  // Operation select lines
  assign op = cpu_exec_pkg::op_t'(OP_SEL);
  assign issue = ISSUE_VALID && (st_q == cpu_exec_pkg::ST_IDLE);
  assign is_rol = (op == cpu_exec_pkg::rotate_left_carry_op);
  assign is_ror = (op == cpu_exec_pkg::rotate_right_carry_op);
  assign is_bst = (op == cpu_exec_pkg::bit_to_flag_op);
  assign is_bld = (op == cpu_exec_pkg::flag_to_bit_op);
  assign is_fset = (op == cpu_exec_pkg::flag_set_op);
  assign is_fclr = (op == cpu_exec_pkg::flag_clear_op);
  assign is_ild = (op == cpu_exec_pkg::indirect_load_op);
  assign is_old = (op == cpu_exec_pkg::offset_load_op);
  assign is_dld = (op == cpu_exec_pkg::direct_load_op);
  assign is_ist = (op == cpu_exec_pkg::indirect_write_op);
  assign is_ost = (op == cpu_exec_pkg::offset_write_op);
  assign is_dst = (op == cpu_exec_pkg::direct_write_op);
  assign is_lpm = (op == cpu_exec_pkg::code_memory_read_op);
  assign is_push = (op == cpu_exec_pkg::stack_push_op);
  assign is_pop = (op == cpu_exec_pkg::stack_pop_op);
  assign is_sleep = (op == cpu_exec_pkg::sleep_op);
  assign is_wdr = (op == cpu_exec_pkg::watchdog_restart_op);

  // Instruction classes
  assign is_dload = is_ild || is_old || is_dld || is_pop;
  assign is_dstore = is_ist || is_ost || is_dst || is_push;
  assign is_multi = is_dload || is_dstore || is_lpm;

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer pair selection and stepping

  logic [1:0] eff_sel;
  logic [1:0] eff_mode;
  logic [4:0] ptr_lo_idx;
  logic [4:0] ptr_hi_idx;
  logic [15:0] ptr_val;
  logic [15:0] ptr_ea;
  logic [15:0] ptr_next;
  logic ptr_wr;

  // Code reads use Z; displacement only on Y or Z
  assign eff_sel = is_lpm ? `PTR_SEL_Z :
                   ((is_old || is_ost) && (PTR_SEL == `PTR_SEL_X)) ? `PTR_SEL_Y : PTR_SEL; // RULE8 RULE12 RULE14
  assign eff_mode = (is_old || is_ost) ? `MODE_PLAIN :
                    (is_lpm && (PTR_MODE == `MODE_PRE_DEC)) ? `MODE_PLAIN : PTR_MODE;

  // Pair indexes, low byte in lower register
  assign ptr_lo_idx = (eff_sel == `PTR_SEL_Y) ? `PTR_Y_LO :
                      (eff_sel == `PTR_SEL_Z) ? `PTR_Z_LO : `PTR_X_LO; // RULE19
  assign ptr_hi_idx = ptr_lo_idx | 5'h01; // RULE19
  assign ptr_val = {rf_q[ptr_hi_idx], rf_q[ptr_lo_idx]}; // RULE19

  pointer_step #(
    .WIDTH(16)
  ) u_ptr_step (
    .base(ptr_val),
    .mode(eff_mode),
    .use_disp(is_old || is_ost),
    .disp(DISP_Q),
    .eff_addr(ptr_ea),
    .next_ptr(ptr_next)
  );

  // Pointer write back on increment or decrement
  assign ptr_wr = issue && (is_ild || is_ist || is_lpm) && (eff_mode != `MODE_PLAIN); // RULE6 RULE7 RULE10 RULE11

  ////////////////////////////////////////////////////////////////////////////////
  // Bit and rotate datapath

  logic [7:0] rot_res;
  logic rot_c;
  logic rot_z;
  logic rot_n;
  logic rot_v;
  logic bit_val;
  logic [7:0] bld_res;

  rotate_bit_unit u_rot (
    .operand(rf_q[is_bst ? SRC_REG : DST_REG]),
    .carry_in(flags_q[`FLAG_C]),
    .dir_right(is_ror),
    .bit_sel(BIT_SEL),
    .t_in(flags_q[`FLAG_T]),
    .rotated(rot_res),
    .carry_out(rot_c),
    .zero_out(rot_z),
    .neg_out(rot_n),
    .ovf_out(rot_v),
    .bit_out(bit_val),
    .bit_inserted(bld_res)
  );

  // Single-cycle register result
  logic wa_en;
  logic [7:0] wa_data;
  assign wa_en = issue && (is_rol || is_ror || is_bld); // RULE1 RULE2 RULE4
  assign wa_data = is_bld ? bld_res : rot_res;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag update

  always_comb begin
    flags_d = flags_q;
    if (issue && (is_rol || is_ror)) begin
      flags_d[`FLAG_C] = rot_c; // RULE1 RULE2
      flags_d[`FLAG_Z] = rot_z; // RULE1 RULE2
      flags_d[`FLAG_N] = rot_n; // RULE1 RULE2
      flags_d[`FLAG_V] = rot_v; // RULE1 RULE2
    end else if (issue && is_bst) begin
      flags_d[`FLAG_T] = bit_val; // RULE3
    end else if (issue && is_fset) begin
      flags_d[FLAG_SEL] = 1'b1; // RULE5
    end else if (issue && is_fclr) begin
      flags_d[FLAG_SEL] = 1'b0; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory address, stack pointer and cycle count

  logic [15:0] sp_inc;
  logic [15:0] sp_dec;
  logic [15:0] daddr_d;
  logic [4:0] ld_idx_d;
  logic [1:0] cyc;

  // Stack grows downward: push writes then drops, pop bumps then reads
  assign sp_inc = sp_q + 16'h0001;
  assign sp_dec = sp_q - 16'h0001;
  assign sp_d = (issue && is_push) ? sp_dec : (issue && is_pop) ? sp_inc : sp_q; // RULE15 RULE16

  // Data address per addressing mode
  assign daddr_d = (is_dld || is_dst) ? DIRECT_ADDR : // RULE9 RULE13
                   is_push ? sp_q : // RULE15
                   is_pop ? sp_inc : ptr_ea; // RULE16 RULE6 RULE7 RULE8

  // Load destination, R0 when code read has no operand
  assign ld_idx_d = (is_lpm && NO_OPERAND) ? `REG_R0 : DST_REG; // RULE14

  // Cycles taken by this instruction
  assign cyc = is_lpm ? `CYC_CODE : is_multi ? `CYC_DATA : `CYC_SINGLE; // RULE14

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      cpu_exec_pkg::ST_IDLE: begin
        if (issue && is_multi) begin
          st_d = cpu_exec_pkg::ST_BUSY;
          cnt_d = cyc - 2'h1;
        end
      end
      cpu_exec_pkg::ST_BUSY: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          st_d = cpu_exec_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = cpu_exec_pkg::ST_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end

  logic last_cyc;
  logic ld_wr;
  logic [7:0] ld_data;
  assign last_cyc = (st_q == cpu_exec_pkg::ST_BUSY) && (cnt_q == 2'h1);
  assign ld_wr = last_cyc && (drd_q || prd_q); // RULE6 RULE7 RULE9 RULE14 RULE16
  assign ld_data = prd_q ? PMEM_RDATA : DMEM_RDATA;

  // Sequencer registers
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= cpu_exec_pkg::ST_IDLE;
      cnt_q <= 2'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Working registers

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= `REG_RESET;
      end
    end else begin
      if (wa_en) begin
        rf_q[DST_REG] <= wa_data; // RULE1 RULE2 RULE4
      end
      if (ptr_wr) begin
        rf_q[ptr_lo_idx] <= ptr_next[7:0]; // RULE19
        rf_q[ptr_hi_idx] <= ptr_next[15:8]; // RULE19
      end
      if (ld_wr) begin
        rf_q[ld_idx_q] <= ld_data; // RULE6 RULE14 RULE16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status and stack pointer

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flags_q <= `FLAGS_REGISTER_RESET;
      sp_q <= `SP_RESET;
    end else begin
      flags_q <= flags_d;
      sp_q <= sp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory strobes, held for the whole access

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      daddr_q <= 16'h0000;
      drd_q <= 1'b0;
      dwr_q <= 1'b0;
      wdata_q <= 8'h00;
      paddr_q <= 16'h0000;
      prd_q <= 1'b0;
      ld_idx_q <= 5'h00;
    end else if (issue) begin
      daddr_q <= daddr_d;
      drd_q <= is_dload; // RULE6 RULE7 RULE8 RULE9 RULE16
      dwr_q <= is_dstore; // RULE10 RULE11 RULE12 RULE13 RULE15
      wdata_q <= rf_q[SRC_REG];
      paddr_q <= ptr_val; // RULE14
      prd_q <= is_lpm; // RULE14
      ld_idx_q <= ld_idx_d;
    end else if (last_cyc) begin
      drd_q <= 1'b0;
      dwr_q <= 1'b0;
      prd_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion and control pulses

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      done_q <= 1'b0;
      sleep_q <= 1'b0;
      wdr_q <= 1'b0;
    end else begin
      done_q <= (issue && !is_multi) || last_cyc;
      sleep_q <= issue && is_sleep; // RULE17
      wdr_q <= issue && is_wdr; // RULE18
    end
  end

  // Register observation port
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dbg_q <= 8'h00;
    end else begin
      dbg_q <= rf_q[DBG_REG_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign ISSUE_READY = (st_q == cpu_exec_pkg::ST_IDLE);
  assign DONE = done_q;
  assign DMEM_ADDR = daddr_q;
  assign DMEM_RD_EN = drd_q;
  assign DMEM_WR_EN = dwr_q;
  assign DMEM_WDATA = wdata_q;
  assign PMEM_ADDR = paddr_q;
  assign PMEM_RD_EN = prd_q;
  assign SLEEP_REQ = sleep_q;
  assign WDOG_RESTART = wdr_q;
  assign FLAGS_OUT = flags_q;
  assign STACK_PTR = sp_q;
  assign DBG_REG_DATA = dbg_q;

endmodule
`default_nettype wire

// ---- hdl/cpu_exec_consts.svh ----
`ifndef CPU_EXEC_CONSTS_SVH
`define CPU_EXEC_CONSTS_SVH

// Status flag bit positions
`define FLAG_C 3'h0
`define FLAG_Z 3'h1
`define FLAG_N 3'h2
`define FLAG_V 3'h3
`define FLAG_S 3'h4
`define FLAG_H 3'h5
`define FLAG_T 3'h6
`define FLAG_I 3'h7

// Low register of each pointer pair, and register R0
`define PTR_X_LO 5'h1a
`define PTR_Y_LO 5'h1c
`define PTR_Z_LO 5'h1e
`define REG_R0 5'h00

// Pointer select codes
`define PTR_SEL_X 2'h0
`define PTR_SEL_Y 2'h1
`define PTR_SEL_Z 2'h2

// Pointer addressing modes
`define MODE_PLAIN 2'h0
`define MODE_POST_INC 2'h1
`define MODE_PRE_DEC 2'h2

// Reset values
`define FLAGS_REGISTER_RESET 8'h00
`define SP_RESET 16'h00ff
`define REG_RESET 8'h00

// Cycle counts per instruction class
`define CYC_SINGLE 2'h1
`define CYC_DATA 2'h2
`define CYC_CODE 2'h3

`endif

// ---- hdl/cpu_exec_pkg.sv ----
package cpu_exec_pkg;

  // Decoded operation presented on the issue port
  typedef enum logic [4:0] {
    nop_op,
    rotate_left_carry_op,
    rotate_right_carry_op,
    bit_to_flag_op,
    flag_to_bit_op,
    flag_set_op,
    flag_clear_op,
    indirect_load_op,
    offset_load_op,
    direct_load_op,
    indirect_write_op,
    offset_write_op,
    direct_write_op,
    code_memory_read_op,
    stack_push_op,
    stack_pop_op,
    sleep_op,
    watchdog_restart_op
  } op_t;

  // Sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } state_t;

endpackage

// ---- hdl/rotate_bit_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
module rotate_bit_unit (
  input wire logic [7:0] operand,
  input wire logic carry_in,
  input wire logic dir_right,
  input wire logic [2:0] bit_sel,
  input wire logic t_in,
  output logic [7:0] rotated,
  output logic carry_out,
  output logic zero_out,
  output logic neg_out,
  output logic ovf_out,
  output logic bit_out,
  output logic [7:0] bit_inserted
);

  logic [7:0] bit_mask;

  // Rotate through carry in either direction
  assign rotated = dir_right ? {carry_in, operand[7:1]} : {operand[6:0], carry_in};
  assign carry_out = dir_right ? operand[0] : operand[7];

  // Result flags of the rotate
  assign zero_out = (rotated == 8'h00);
  assign neg_out = rotated[7];
  assign ovf_out = rotated[7] ^ carry_out;

  // Selected bit out, transfer flag into selected bit
  assign bit_out = operand[bit_sel];
  assign bit_mask = 8'h01 << bit_sel;
  assign bit_inserted = t_in ? (operand | bit_mask) : (operand & ~bit_mask);

endmodule
`default_nettype wire

// ---- hdl/pointer_step.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "cpu_exec_consts.svh"
module pointer_step #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] base,
  input wire logic [1:0] mode,
  input wire logic use_disp,
  input wire logic [5:0] disp,
  output logic [WIDTH-1:0] eff_addr,
  output logic [WIDTH-1:0] next_ptr
);

  logic [WIDTH-1:0] inc_val;
  logic [WIDTH-1:0] dec_val;
  logic [WIDTH-1:0] disp_val;

  // Full-width carry and borrow across both bytes
  assign inc_val = base + {{(WIDTH-1){1'b0}}, 1'b1};
  assign dec_val = base - {{(WIDTH-1){1'b0}}, 1'b1};
  assign disp_val = base + {{(WIDTH-6){1'b0}}, disp};

  // Access address and updated pointer
  assign eff_addr = (mode == `MODE_PRE_DEC) ? dec_val : (use_disp ? disp_val : base);
  assign next_ptr = (mode == `MODE_POST_INC) ? inc_val :
                    (mode == `MODE_PRE_DEC) ? dec_val : base;

endmodule
`default_nettype wire

// ---- verif/exec_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module exec_checker (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic ISSUE_VALID,
  input wire logic ISSUE_READY,
  input wire logic [4:0] OP_SEL,
  input wire logic [15:0] DIRECT_ADDR,
  input wire logic DONE,
  input wire logic [15:0] DMEM_ADDR,
  input wire logic DMEM_RD_EN,
  input wire logic DMEM_WR_EN,
  input wire logic PMEM_RD_EN,
  input wire logic SLEEP_REQ,
  input wire logic WDOG_RESTART,
  input wire logic [7:0] FLAGS_OUT,
  input wire logic [15:0] STACK_PTR
);
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff SYS_RST;
  logic take;
  // Accepted issue
  assign take = ISSUE_VALID && ISSUE_READY;
  // Data op stalls one cycle, then finishes
  sequence s_data_tail;
    !ISSUE_READY ##1 (DONE && ISSUE_READY);
  endsequence
  // Code read holds its strobe two cycles
  sequence s_code_tail;
    (PMEM_RD_EN && !ISSUE_READY) [*2] ##1 DONE;
  endsequence
  chk_single_done: assert property (take && OP_SEL inside {[5'h01:5'h06], 5'h10, 5'h11} |=> DONE)
    else $error("single cycle op late");
  chk_data_two: assert property (take && OP_SEL inside {[5'h07:5'h0c], 5'h0e, 5'h0f} |=> s_data_tail)
    else $error("data op not two cycles");
  chk_code_three: assert property (take && OP_SEL == 5'h0d |=> s_code_tail)
    else $error("code read not three cycles");
  chk_sleep_pulse: assert property (take && OP_SEL == 5'h10 |=> SLEEP_REQ ##1 !SLEEP_REQ)
    else $error("sleep request wrong");
  chk_wdog_pulse: assert property (take && OP_SEL == 5'h11 |=> WDOG_RESTART ##1 !WDOG_RESTART)
    else $error("watchdog restart wrong");
  chk_direct_addr: assert property (take && OP_SEL inside {5'h09, 5'h0c} |=> DMEM_ADDR == $past(DIRECT_ADDR))
    else $error("direct address wrong");
  chk_flags_kept: assert property (take && OP_SEL inside {[5'h07:5'h0f]} |=> $stable(FLAGS_OUT) [*2])
    else $error("transfer changed flags");
  chk_push_stack: assert property (take && OP_SEL == 5'h0e |=>
    DMEM_WR_EN && DMEM_ADDR == $past(STACK_PTR) && STACK_PTR == $past(STACK_PTR) - 16'h0001)
    else $error("push address wrong");
  chk_pop_stack: assert property (take && OP_SEL == 5'h0f |=>
    DMEM_RD_EN && DMEM_ADDR == STACK_PTR && STACK_PTR == $past(STACK_PTR) + 16'h0001)
    else $error("pop address wrong");
endmodule

bind cpu_bitop_transfer_exec exec_checker i_exec_checker (
  .REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST),
  .ISSUE_VALID(ISSUE_VALID),
  .ISSUE_READY(ISSUE_READY),
  .OP_SEL(OP_SEL),
  .DIRECT_ADDR(DIRECT_ADDR),
  .DONE(DONE),
  .DMEM_ADDR(DMEM_ADDR),
  .DMEM_RD_EN(DMEM_RD_EN),
  .DMEM_WR_EN(DMEM_WR_EN),
  .PMEM_RD_EN(PMEM_RD_EN),
  .SLEEP_REQ(SLEEP_REQ),
  .WDOG_RESTART(WDOG_RESTART),
  .FLAGS_OUT(FLAGS_OUT),
  .STACK_PTR(STACK_PTR)
);
`default_nettype wire

// ---- verif/data_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
  input wire logic clk,
  input wire logic [15:0] d_addr,
  input wire logic d_rd,
  input wire logic d_wr,
  input wire logic [7:0] d_wdata,
  output logic [7:0] d_rdata,
  input wire logic [15:0] p_addr,
  input wire logic p_rd,
  output logic [7:0] p_rdata
);
  logic [7:0] mem [256];
  // Same-cycle reads, inverted value when not enabled
  assign d_rdata = d_rd ? mem[d_addr[7:0]] : ~mem[d_addr[7:0]];
  assign p_rdata = p_rd ? (p_addr[7:0] ^ p_addr[15:8] ^ 8'hc3) : ~p_addr[7:0];
  // Write lands at the edge ending the strobe cycle
  always @(posedge clk) begin
    if (d_wr) begin
      mem[d_addr[7:0]] <= d_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- verif/cpu_bitop_transfer_exec_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module cpu_bitop_transfer_exec_bench;
  logic REF_CLK, SYS_RST, ISSUE_VALID, ISSUE_READY, NO_OPERAND, DONE;
  logic DMEM_RD_EN, DMEM_WR_EN, PMEM_RD_EN, SLEEP_REQ, WDOG_RESTART;
  logic [1:0] pulse;
  logic [4:0] OP_SEL, DST_REG, SRC_REG, DBG_REG_SEL;
  logic [2:0] BIT_SEL, FLAG_SEL;
  logic [1:0] PTR_SEL, PTR_MODE;
  logic [5:0] DISP_Q;
  logic [15:0] DIRECT_ADDR, DMEM_ADDR, PMEM_ADDR, STACK_PTR;
  logic [7:0] DMEM_WDATA, DMEM_RDATA, PMEM_RDATA, FLAGS_OUT, DBG_REG_DATA;
  int fails;
  int checks;

  cpu_bitop_transfer_exec i_cpu_bitop_transfer_exec (.*);
  data_mem_model i_data_mem_model (
    .clk(REF_CLK), .d_addr(DMEM_ADDR), .d_rd(DMEM_RD_EN), .d_wr(DMEM_WR_EN),
    .d_wdata(DMEM_WDATA), .d_rdata(DMEM_RDATA),
    .p_addr(PMEM_ADDR), .p_rd(PMEM_RD_EN), .p_rdata(PMEM_RDATA)
  );

  // 50 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Issue one op and count cycles up to its done pulse
  task automatic run(input logic [4:0] op, input int cyc);
    int n;
    OP_SEL = op;
    ISSUE_VALID = 1'b1;
    @(negedge REF_CLK);
    ISSUE_VALID = 1'b0;
    n = 1;
    pulse = {SLEEP_REQ, WDOG_RESTART};
    while (DONE !== 1'b1 && n < 8) begin
      @(negedge REF_CLK);
      n++;
    end
    if (n == 8) begin
      fails++;
      print_verdict();
    end
    chk(16'(n), 16'(cyc));
  endtask

  task automatic creg(input logic [4:0] r, input logic [7:0] exp);
    DBG_REG_SEL = r;
    @(negedge REF_CLK);
    chk(DBG_REG_DATA, exp);
  endtask

  task automatic ldr(input logic [4:0] r, input logic [7:0] v);
    i_data_mem_model.mem[8'hf0] = v;
    DST_REG = r;
    DIRECT_ADDR = 16'h00f0;
    run(5'h09, 2);
    creg(r, v);
  endtask

  task automatic t_rotate();
    ldr(5'h10, 8'h81);
    ldr(5'h11, 8'h80);
    FLAG_SEL = 3'h0;
    run(5'h05, 1);
    DST_REG = 5'h10;
    run(5'h01, 1);
    creg(5'h10, 8'h03);
    chk(FLAGS_OUT, 8'h09);
    run(5'h02, 1);
    creg(5'h10, 8'h81);
    chk(FLAGS_OUT, 8'h05);
    run(5'h06, 1);
    DST_REG = 5'h11;
    run(5'h01, 1);
    creg(5'h11, 8'h00);
    chk(FLAGS_OUT, 8'h0b);
  endtask

  task automatic t_flags();
    logic [7:0] e;
    e = 8'h0b;
    for (int f = 0; f < 16; f++) begin
      FLAG_SEL = f[2:0];
      run(f < 8 ? 5'h05 : 5'h06, 1);
      e[f[2:0]] = (f < 8);
      chk(FLAGS_OUT, e);
    end
  endtask

  task automatic t_bits();
    ldr(5'h12, 8'h20);
    SRC_REG = 5'h12;
    BIT_SEL = 3'h5;
    run(5'h03, 1);
    chk(FLAGS_OUT, 8'h40);
    DST_REG = 5'h13;
    BIT_SEL = 3'h2;
    run(5'h04, 1);
    creg(5'h13, 8'h04);
    chk(FLAGS_OUT, 8'h40);
    BIT_SEL = 3'h4;
    run(5'h03, 1);
    chk(FLAGS_OUT, 8'h00);
  endtask

  task automatic t_load();
    ldr(5'h1a, 8'hff);
    ldr(5'h1b, 8'h00);
    i_data_mem_model.mem[8'hff] = 8'h3c;
    DST_REG = 5'h14;
    PTR_SEL = 2'h0;
    PTR_MODE = 2'h1;
    run(5'h07, 2);
    creg(5'h14, 8'h3c);
    creg(5'h1a, 8'h00);
    creg(5'h1b, 8'h01);
    DST_REG = 5'h15;
    PTR_MODE = 2'h2;
    run(5'h07, 2);
    creg(5'h15, 8'h3c);
    creg(5'h1b, 8'h00);
  endtask

  task automatic t_store();
    ldr(5'h1c, 8'h7f);
    ldr(5'h1d, 8'h00);
    SRC_REG = 5'h10;
    PTR_SEL = 2'h1;
    PTR_MODE = 2'h1;
    run(5'h0a, 2);
    chk(i_data_mem_model.mem[8'h7f], 8'h81);
    creg(5'h1c, 8'h80);
    SRC_REG = 5'h13;
    PTR_MODE = 2'h2;
    run(5'h0a, 2);
    chk(i_data_mem_model.mem[8'h7f], 8'h04);
    creg(5'h1c, 8'h7f);
    SRC_REG = 5'h10;
    DISP_Q = 6'h3f;
    run(5'h0b, 2);
    chk(i_data_mem_model.mem[8'hbe], 8'h81);
    creg(5'h1c, 8'h7f);
    i_data_mem_model.mem[8'h80] = 8'h5a;
    DST_REG = 5'h16;
    DISP_Q = 6'h01;
    run(5'h08, 2);
    creg(5'h16, 8'h5a);
    SRC_REG = 5'h13;
    DIRECT_ADDR = 16'h0090;
    run(5'h0c, 2);
    chk(i_data_mem_model.mem[8'h90], 8'h04);
    chk(FLAGS_OUT, 8'h00);
  endtask

  task automatic t_code();
    ldr(5'h1e, 8'hff);
    ldr(5'h1f, 8'h00);
    NO_OPERAND = 1'b1;
    DST_REG = 5'h05;
    PTR_MODE = 2'h1;
    run(5'h0d, 3);
    creg(5'h00, 8'h3c);
    creg(5'h05, 8'h00);
    creg(5'h1f, 8'h01);
    NO_OPERAND = 1'b0;
    DST_REG = 5'h17;
    PTR_MODE = 2'h0;
    run(5'h0d, 3);
    creg(5'h17, 8'hc2);
    creg(5'h1e, 8'h00);
  endtask

  task automatic t_misc();
    SRC_REG = 5'h10;
    run(5'h0e, 2);
    chk(STACK_PTR, 16'h00fe);
    chk(i_data_mem_model.mem[8'hff], 8'h81);
    DST_REG = 5'h18;
    run(5'h0f, 2);
    creg(5'h18, 8'h81);
    chk(STACK_PTR, 16'h00ff);
    run(5'h10, 1);
    chk(pulse, 16'h0002);
    run(5'h11, 1);
    chk(pulse, 16'h0001);
    chk(FLAGS_OUT, 8'h00);
  endtask

  // Reset, then the scenarios in order
  initial begin
    {ISSUE_VALID, NO_OPERAND, OP_SEL, DST_REG, SRC_REG, DBG_REG_SEL} = '0;
    {BIT_SEL, FLAG_SEL, PTR_SEL, PTR_MODE, DISP_Q, DIRECT_ADDR} = '0;
    fails = 0;
    checks = 0;
    SYS_RST = 1'b1;
    repeat (16) @(negedge REF_CLK);
    chk(STACK_PTR, 16'h00ff);
    chk(FLAGS_OUT, 8'h00);
    SYS_RST = 1'b0;
    t_rotate();
    t_flags();
    t_bits();
    t_load();
    t_store();
    t_code();
    t_misc();
    print_verdict();
  end
endmodule
`default_nettype wire
